//--- hw/ed_pkg.sv
// Constants, field layout and state encodings of the energy-detect power control block.
// Assumes a single 10 MHz core clock and a 16-bit register port behind the management interface.
//
// Contract
// - Bit 15 enables the feature, off at reset
// - Auto wake once data threshold reached
// - Auto sleep once line energy disappears
// - Manual bit toggles power state, self-clears
// - Four pulses per power-up, one if disabled
// - Bit 10 shows powered state
// - Error threshold flag, no action, clear-on-read
// - Data threshold flag, clear-on-read
// - Bits 7:4 hold error threshold, reset 1
// - Bits 3:0 hold data threshold, reset 1
// - Counters reset after two idle seconds
package ed_pkg;

    localparam int CLK_PERIOD_NS = 100;

    // Field positions of energy_detect_control
    localparam int POS_ENABLE = 15;
    localparam int POS_AUTO_WAKE = 14;
    localparam int POS_AUTO_SLEEP = 13;
    localparam int POS_MANUAL = 12;
    localparam int POS_BURST_OFF = 11;
    localparam int POS_POWERED = 10;
    localparam int POS_ERR_HIT = 9;
    localparam int POS_DATA_HIT = 8;
    localparam int POS_ERR_THR_LSB = 4;
    localparam int POS_DATA_THR_LSB = 0;
    localparam int THR_WIDTH = 4;

    // Reset values
    localparam logic RST_ENABLE = 1'h0;
    localparam logic RST_AUTO_WAKE = 1'h1;
    localparam logic RST_AUTO_SLEEP = 1'h1;
    localparam logic RST_BURST_OFF = 1'h0;
    localparam logic [THR_WIDTH-1:0] RST_ERR_THR = 4'h1;
    localparam logic [THR_WIDTH-1:0] RST_DATA_THR = 4'h1;

    // Pulses sent after each power-up
    localparam logic [2:0] BURST_PULSES = 3'h4;
    localparam logic [2:0] SINGLE_PULSE = 3'h1;

    // Timing, in its own unit, and derived cycle counts (least times round up)
    localparam int SEQ_TIME_NS = 2000;
    localparam int PULSE_TIME_NS = 200;
    localparam int GAP_TIME_NS = 800;
    localparam int IDLE_TIME_MS = 2000;
    localparam int SEQ_CYCLES = (SEQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PULSE_CYCLES = (PULSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GAP_CYCLES = (GAP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int IDLE_CYCLES = IDLE_TIME_MS * (1000000 / CLK_PERIOD_NS);

    typedef enum logic [1:0] {
        st_up,
        st_going_down,
        st_down,
        st_going_up
    } power_state_t;

endpackage

//--- hw/event_counter.sv
// Saturating event counter with a threshold compare.
// Assumes inc_in is a one-cycle pulse from logic on the same clock.
`timescale 1ns/1ps
module event_counter
    import ed_pkg::*;
#(
    parameter int WIDTH = 4
) (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic clear_in,
    input wire logic inc_in,
    input wire logic [WIDTH-1:0] threshold_in,
    output logic [WIDTH-1:0] count_out,
    output logic hit_out
);

    typedef struct packed {
        logic [WIDTH-1:0] count;
        logic hit;
    } counter_state_t;

    localparam logic [WIDTH-1:0] COUNT_MAX = {WIDTH{1'b1}};
    localparam logic [WIDTH-1:0] COUNT_ONE = {{(WIDTH-1){1'b0}}, 1'b1};

    counter_state_t s;
    counter_state_t next_s;

    always_comb begin
        next_s = s;
        if (clear_in) begin
            // An event in the clearing cycle still counts as the first one
            next_s.count = inc_in ? COUNT_ONE : '0;
        end else if (inc_in && s.count != COUNT_MAX) begin
            next_s.count = WIDTH'(s.count + COUNT_ONE);
        end
        next_s.hit = inc_in && (next_s.count >= threshold_in);
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign count_out = s.count;
    assign hit_out = s.hit;

endmodule // event_counter

//--- hw/energy_detect_power_control.sv
// Energy-detect power manager: event counting, power sequencing, pulse bursts
// and the energy_detect_control register.
// Assumes line_energy_in, data_event_in and error_event_in come from the analog
// front end, asynchronous to core_clk_in; the register port is on core_clk_in.
// Bit 10 is only meaningful while the feature is enabled.
`timescale 1ns/1ps
module energy_detect_power_control
    import ed_pkg::*;
#(
    parameter int IDLE_LIMIT = IDLE_CYCLES,
    parameter int SEQ_LIMIT = SEQ_CYCLES
) (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic line_energy_in,
    input wire logic data_event_in,
    input wire logic error_event_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [15:0] reg_wdata_in,
    output logic [15:0] reg_rdata_out,
    output logic rx_power_out,
    output logic data_pulse_out,
    output logic sequence_busy_out
);

    localparam int IDLE_W = $clog2(IDLE_LIMIT + 1);
    localparam int SEQ_W = $clog2(SEQ_LIMIT + 1);
    localparam int PHASE_W = $clog2(PULSE_CYCLES + GAP_CYCLES + 1);
    localparam logic [IDLE_W-1:0] IDLE_LAST = IDLE_W'(IDLE_LIMIT - 1);
    localparam logic [SEQ_W-1:0] SEQ_LAST = SEQ_W'(SEQ_LIMIT - 1);
    localparam logic [PHASE_W-1:0] PULSE_END = PHASE_W'(PULSE_CYCLES);
    localparam logic [PHASE_W-1:0] PHASE_LAST = PHASE_W'(PULSE_CYCLES + GAP_CYCLES - 1);
    // Register image at reset, assembled from the field defaults
    localparam logic [15:0] RST_IMAGE = {RST_ENABLE, RST_AUTO_WAKE, RST_AUTO_SLEEP, 1'b0,
                                         RST_BURST_OFF, 3'h0, RST_ERR_THR, RST_DATA_THR};

    typedef struct packed {
        // Synchronisers and edge history
        logic energy_meta;
        logic energy_sync;
        logic data_meta;
        logic data_sync;
        logic data_prev;
        logic error_meta;
        logic error_sync;
        logic error_prev;
        // Register fields
        logic enable;
        logic auto_wake;
        logic auto_sleep;
        logic manual_toggle;
        logic pulse_burst_off;
        logic powered_state;
        logic error_threshold_hit;
        logic data_threshold_hit;
        logic [THR_WIDTH-1:0] error_threshold;
        logic [THR_WIDTH-1:0] data_threshold;
        // Sequencing
        power_state_t state;
        logic [SEQ_W-1:0] seq_timer;
        logic [IDLE_W-1:0] idle_timer;
        logic rx_power;
        // Pulse burst
        logic [2:0] pulses_left;
        logic [PHASE_W-1:0] phase;
        logic pulse;
        // Read image
        logic [15:0] rdata;
    } ctrl_state_t;

    ctrl_state_t s;
    ctrl_state_t next_s;

    logic data_evt;
    logic error_evt;
    logic idle_timeout;
    logic seq_start;
    logic counter_clear;
    logic data_hit;
    logic error_hit;

    // Rising edges of the synchronised event lines, gated by the enable
    assign data_evt = s.enable && s.data_sync && !s.data_prev;
    assign error_evt = s.enable && s.error_sync && !s.error_prev;

    // Silence on the data event line for the whole idle window
    assign idle_timeout = s.enable && !data_evt && (s.idle_timer == IDLE_LAST);

    // A new sequence starts from fresh counts so that old events cannot re-trigger it
    assign seq_start = (next_s.state == st_going_up || next_s.state == st_going_down)
                       && (next_s.state != s.state);
    assign counter_clear = idle_timeout || seq_start || !s.enable;

    event_counter #(
        .WIDTH(THR_WIDTH)
    ) data_counter (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .clear_in(counter_clear),
        .inc_in(data_evt),
        .threshold_in(s.data_threshold),
        .count_out(),
        .hit_out(data_hit)
    );

    // Error counts are informational only, never acted on
    event_counter #(
        .WIDTH(THR_WIDTH)
    ) error_counter (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .clear_in(counter_clear),
        .inc_in(error_evt),
        .threshold_in(s.error_threshold),
        .count_out(),
        .hit_out(error_hit)
    );

    always_comb begin
        next_s = s;

        // Two flip-flops before any logic reads a front-end line
        next_s.energy_meta = line_energy_in;
        next_s.energy_sync = s.energy_meta;
        next_s.data_meta = data_event_in;
        next_s.data_sync = s.data_meta;
        next_s.data_prev = s.data_sync;
        next_s.error_meta = error_event_in;
        next_s.error_sync = s.error_meta;
        next_s.error_prev = s.error_sync;

        // Idle window restarts on every data event
        // A timeout restarts it too, so silence clears the counters once per window
        if (data_evt || !s.enable || idle_timeout) begin
            next_s.idle_timer = '0;
        end else begin
            next_s.idle_timer = IDLE_W'(s.idle_timer + 1'b1);
        end

        // Sticky flags: a read clears, a hit in the same cycle wins
        if (reg_rd_in) begin
            next_s.error_threshold_hit = 1'b0;
            next_s.data_threshold_hit = 1'b0;
        end
        if (error_hit) begin
            next_s.error_threshold_hit = 1'b1;
        end
        if (data_hit) begin
            next_s.data_threshold_hit = 1'b1;
        end

        // Burst generator: pulse high, then gap, per pulse left
        if (s.pulses_left != 3'h0) begin
            next_s.pulse = (s.phase < PULSE_END);
            if (s.phase == PHASE_LAST) begin
                next_s.phase = '0;
                next_s.pulses_left = 3'(s.pulses_left - 3'h1);
            end else begin
                next_s.phase = PHASE_W'(s.phase + 1'b1);
            end
        end else begin
            next_s.pulse = 1'b0;
            next_s.phase = '0;
        end

        // Power sequencing
        if (!s.enable) begin
            // Feature off: receive section stays powered, nothing pending
            next_s.state = st_up;
            next_s.rx_power = 1'b1;
            next_s.seq_timer = '0;
            next_s.manual_toggle = 1'b0;
            next_s.pulses_left = 3'h0;
            next_s.pulse = 1'b0;
        end else begin
            // A manual request is consumed in the cycle it is seen
            next_s.manual_toggle = 1'b0;
            unique case (s.state)
                st_up: begin
                    if (s.manual_toggle) begin
                        next_s.state = st_going_down;
                    end else if (s.auto_sleep && !s.energy_sync) begin
                        next_s.state = st_going_down;
                    end
                    next_s.seq_timer = '0;
                end
                st_going_down: begin
                    // Cut any burst so no pulse leaks into power down
                    next_s.pulses_left = 3'h0;
                    next_s.pulse = 1'b0;
                    if (s.manual_toggle) begin
                        next_s.state = st_going_up;
                        next_s.seq_timer = '0;
                    end else if (s.seq_timer == SEQ_LAST) begin
                        next_s.state = st_down;
                        next_s.rx_power = 1'b0;
                        next_s.powered_state = 1'b0;
                        next_s.seq_timer = '0;
                    end else begin
                        next_s.seq_timer = SEQ_W'(s.seq_timer + 1'b1);
                    end
                end
                st_down: begin
                    // Rx power returns at once so the section settles during the sequence
                    if (s.manual_toggle) begin
                        next_s.state = st_going_up;
                        next_s.rx_power = 1'b1;
                    end else if (s.auto_wake && data_hit) begin
                        next_s.state = st_going_up;
                        next_s.rx_power = 1'b1;
                    end
                    next_s.seq_timer = '0;
                end
                st_going_up: begin
                    next_s.rx_power = 1'b1;
                    if (s.manual_toggle) begin
                        next_s.state = st_going_down;
                        next_s.seq_timer = '0;
                    end else if (s.seq_timer == SEQ_LAST) begin
                        next_s.state = st_up;
                        next_s.powered_state = 1'b1;
                        next_s.seq_timer = '0;
                        next_s.phase = '0;
                        next_s.pulses_left = s.pulse_burst_off ? SINGLE_PULSE
                                                               : BURST_PULSES;
                    end else begin
                        next_s.seq_timer = SEQ_W'(s.seq_timer + 1'b1);
                    end
                end
            endcase
        end

        // Register write; the manual bit only ever sets
        if (reg_wr_in) begin
            next_s.enable = reg_wdata_in[POS_ENABLE];
            next_s.auto_wake = reg_wdata_in[POS_AUTO_WAKE];
            next_s.auto_sleep = reg_wdata_in[POS_AUTO_SLEEP];
            next_s.pulse_burst_off = reg_wdata_in[POS_BURST_OFF];
            next_s.error_threshold =
                reg_wdata_in[POS_ERR_THR_LSB +: THR_WIDTH];
            next_s.data_threshold =
                reg_wdata_in[POS_DATA_THR_LSB +: THR_WIDTH];
            if (reg_wdata_in[POS_MANUAL] && reg_wdata_in[POS_ENABLE]) begin
                next_s.manual_toggle = 1'b1;
            end
        end

        // Read image always matches the flops holding the fields
        next_s.rdata = '0;
        next_s.rdata[POS_ENABLE] = next_s.enable;
        next_s.rdata[POS_AUTO_WAKE] = next_s.auto_wake;
        next_s.rdata[POS_AUTO_SLEEP] = next_s.auto_sleep;
        next_s.rdata[POS_MANUAL] = next_s.manual_toggle;
        next_s.rdata[POS_BURST_OFF] = next_s.pulse_burst_off;
        next_s.rdata[POS_POWERED] = next_s.powered_state;
        next_s.rdata[POS_ERR_HIT] = next_s.error_threshold_hit;
        next_s.rdata[POS_DATA_HIT] = next_s.data_threshold_hit;
        next_s.rdata[POS_ERR_THR_LSB +: THR_WIDTH] = next_s.error_threshold;
        next_s.rdata[POS_DATA_THR_LSB +: THR_WIDTH] = next_s.data_threshold;
    end

    // Every field gets its power-on value explicitly
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            // Sync chains
            s.energy_meta <= 1'b0;
            s.energy_sync <= 1'b0;
            s.data_meta <= 1'b0;
            s.data_sync <= 1'b0;
            s.data_prev <= 1'b0;
            s.error_meta <= 1'b0;
            s.error_sync <= 1'b0;
            s.error_prev <= 1'b0;
            // Register fields
            s.enable <= RST_ENABLE;
            s.auto_wake <= RST_AUTO_WAKE;
            s.auto_sleep <= RST_AUTO_SLEEP;
            s.manual_toggle <= 1'b0;
            s.pulse_burst_off <= RST_BURST_OFF;
            s.powered_state <= 1'b0;
            s.error_threshold_hit <= 1'b0;
            s.data_threshold_hit <= 1'b0;
            s.error_threshold <= RST_ERR_THR;
            s.data_threshold <= RST_DATA_THR;
            // Sequencer and burst
            s.state <= st_up;
            s.seq_timer <= '0;
            s.idle_timer <= '0;
            s.rx_power <= 1'b1;
            s.pulses_left <= 3'h0;
            s.phase <= '0;
            s.pulse <= 1'b0;
            s.rdata <= RST_IMAGE;
        end else begin
            s <= next_s;
        end
    end

    assign reg_rdata_out = s.rdata;
    assign rx_power_out = s.rx_power;
    assign data_pulse_out = s.pulse;
    // Busy is decoded straight from the state flops
    assign sequence_busy_out = (s.state == st_going_up) || (s.state == st_going_down);

endmodule // energy_detect_power_control

//--- tb/line_partner.sv
// Line-side model: energy level and event pulses seen on the cable.
// Assumes its commands come from the bench on the falling clock edge.
`timescale 1ns/1ps
module line_partner (
    input wire logic core_clk_in,
    input wire logic energy_in,
    input wire logic data_go_in,
    input wire logic err_go_in,
    output logic line_energy_out,
    output logic data_event_out,
    output logic error_event_out
);
    int data_len = 0;
    int err_len = 0;
    // Events stay high four clocks, enough for the two-flop sync
    always @(posedge core_clk_in) begin
        data_len <= data_go_in ? 4 : (data_len > 0 ? data_len - 1 : 0);
        err_len <= err_go_in ? 4 : (err_len > 0 ? err_len - 1 : 0);
    end
    assign line_energy_out = energy_in;
    assign data_event_out = data_len > 0;
    assign error_event_out = err_len > 0;
endmodule // line_partner

//--- tb/energy_detect_power_control_assertions.sv
// Port-level checks of the energy-detect power manager.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module energy_detect_power_control_assertions
    import ed_pkg::*;
#(
    parameter int IDLE_LIMIT = IDLE_CYCLES,
    parameter int SEQ_LIMIT = SEQ_CYCLES
) (
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic line_energy_in,
    input wire logic data_event_in,
    input wire logic error_event_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic [15:0] reg_rdata_out,
    input wire logic rx_power_out,
    input wire logic data_pulse_out,
    input wire logic sequence_busy_out
);
    int run_len;
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) run_len <= 0;
        else run_len <= sequence_busy_out ? run_len + 1 : 0;
    end
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    a_disabled_powered: assert property (
        !reg_rdata_out[15] && $past(!reg_rdata_out[15]) |-> rx_power_out)
        else $error("rx power off while feature disabled");
    a_manual_clears: assert property (
        reg_rdata_out[12] |=> !reg_rdata_out[12])
        else $error("manual bit did not clear itself");
    a_pulse_shape: assert property (
        $rose(data_pulse_out) |-> data_pulse_out[*2] ##1 !data_pulse_out[*8])
        else $error("data pulse shape wrong");
    a_state_after_seq: assert property (
        $changed(reg_rdata_out[10]) |-> $past(sequence_busy_out))
        else $error("power state bit moved without a sequence");
    a_sleep_after_seq: assert property (
        $fell(rx_power_out) |-> $past(sequence_busy_out))
        else $error("rx power dropped without a sequence");
    a_seq_length: assert property (
        $fell(sequence_busy_out) |->
            run_len >= SEQ_LIMIT - 1 && run_len <= SEQ_LIMIT + 1)
        else $error("sequence length wrong");
    a_thr_write: assert property (
        reg_wr_in |=> reg_rdata_out[7:0] == $past(reg_wdata_in[7:0]))
        else $error("threshold fields not written");
    a_thr_hold: assert property (
        !reg_wr_in |=> $stable(reg_rdata_out[7:0]))
        else $error("threshold fields changed without write");
    c_pulse: cover property ($rose(data_pulse_out));
    c_sleep: cover property ($fell(rx_power_out));
    c_err_hit: cover property (reg_rdata_out[9]);
endmodule // energy_detect_power_control_assertions

bind energy_detect_power_control energy_detect_power_control_assertions #(
    .IDLE_LIMIT(IDLE_LIMIT),
    .SEQ_LIMIT(SEQ_LIMIT)
) checker_i (.*);

//--- tb/test_energy_detect_power_control.sv
// Self-checking bench for the energy-detect power manager.
// Assumes shortened idle and sequence counts; line side is line_partner.
`timescale 1ns/1ps
module test_energy_detect_power_control;
    import ed_pkg::*;
    localparam int IDLE_N = 50;
    localparam int SEQ_N = 4;
    logic core_clk_in = 0;
    logic rst_n_in = 0;
    logic energy = 0, data_go = 0, err_go = 0, wr = 0, rd = 0;
    logic [15:0] wdata = 16'h0000;
    logic [15:0] rdata, v;
    logic line_e, data_e, err_e, rx_power, pulse, busy, pulse_d;
    int fails = 0, total_checks = 0, pulses = 0, p0, i, seed = 1;
    int model_reg;
    always #50 core_clk_in = ~core_clk_in;
    always @(posedge core_clk_in) begin
        pulse_d <= pulse;
        if (pulse && !pulse_d) pulses <= pulses + 1;
    end
    line_partner line_partner_i (.core_clk_in(core_clk_in), .energy_in(energy),
        .data_go_in(data_go), .err_go_in(err_go), .line_energy_out(line_e),
        .data_event_out(data_e), .error_event_out(err_e));
    energy_detect_power_control #(.IDLE_LIMIT(IDLE_N), .SEQ_LIMIT(SEQ_N))
    energy_detect_power_control_i (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
        .line_energy_in(line_e), .data_event_in(data_e), .error_event_in(err_e),
        .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
        .rx_power_out(rx_power), .data_pulse_out(pulse), .sequence_busy_out(busy));
    task automatic close_out;
        if (fails == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            fails++;
        end
    endtask
    task automatic wr_reg(input logic [15:0] d);
        @(negedge core_clk_in);
        wdata = d;
        wr = 1;
        @(negedge core_clk_in);
        wr = 0;
        model_reg = d & 16'hE8FF;
    endtask
    // Flags are expected on top of the written fields
    task automatic check_reg(input logic [15:0] flags, input logic [15:0] m);
        @(negedge core_clk_in);
        rd = 1;
        #1 v = rdata;
        @(negedge core_clk_in);
        rd = 0;
        chk(v & m, (16'(model_reg) | flags) & m);
    endtask
    task automatic ev(input logic data);
        @(negedge core_clk_in);
        if (data) data_go = 1;
        else err_go = 1;
        @(negedge core_clk_in);
        data_go = 0;
        err_go = 0;
        repeat (8) @(negedge core_clk_in);
    endtask
    task automatic wait_seq;
        int n;
        n = 0;
        while (busy !== 1'b1 && n < 50) begin
            @(negedge core_clk_in);
            n++;
        end
        while (busy !== 1'b0 && n < 100) begin
            @(negedge core_clk_in);
            n++;
        end
        chk({15'h0, n < 100}, 16'h0001);
        repeat (3) @(negedge core_clk_in);
    endtask
    initial begin
        #(4000 * 100);
        fails++;
        close_out();
    end
    initial begin
        repeat (20) @(negedge core_clk_in);
        rst_n_in = 1;
        model_reg = 16'h6011;
        check_reg(16'h0000, 16'hFFFF);
        for (i = 0; i < 4; i++) begin
            wr_reg(16'($random(seed)) & 16'h68FF);
            check_reg(16'h0000, 16'hFBFF);
        end
        energy = 1;
        // Software keeps crossover detection off while this mode runs
        wr_reg(16'hE02F);
        ev(0);
        ev(0);
        check_reg(16'h0200, 16'hFBFF);
        chk({14'h0, rx_power, busy}, 16'h0002);
        check_reg(16'h0000, 16'hFBFF);
        energy = 0;
        wait_seq;
        chk({15'h0, rx_power}, 16'h0000);
        check_reg(16'h0000, 16'hFFFF);
        wr_reg(16'hE022);
        ev(1);
        repeat (IDLE_N + 20) @(negedge core_clk_in);
        ev(1);
        chk({15'h0, rx_power}, 16'h0000);
        energy = 1;
        p0 = pulses;
        ev(1);
        ev(1);
        wait_seq;
        chk({15'h0, rx_power}, 16'h0001);
        check_reg(16'h0500, 16'hFFFF);
        repeat (60) @(negedge core_clk_in);
        chk(16'(pulses - p0), 16'h0004);
        wr_reg(16'hF822);
        wait_seq;
        chk({15'h0, rx_power}, 16'h0000);
        check_reg(16'h0000, 16'hFFFF);
        p0 = pulses;
        wr_reg(16'hF822);
        wait_seq;
        repeat (30) @(negedge core_clk_in);
        chk(16'(pulses - p0), 16'h0001);
        // Automatic actions off: no sleep on silence, no wake on data hit
        wr_reg(16'h8022);
        energy = 0;
        repeat (20) @(negedge core_clk_in);
        chk({14'h0, rx_power, busy}, 16'h0002);
        wr_reg(16'h9022);
        wait_seq;
        ev(1);
        ev(1);
        chk({15'h0, rx_power}, 16'h0000);
        check_reg(16'h0100, 16'hFFFF);
        close_out();
    end
endmodule // test_energy_detect_power_control
